/* watchdog_pkg.sv */
// Package with the watchdog register map, reset values and timing constants.
package watchdog_pkg;
  localparam logic [7:0] RELOAD_UPPER_BYTE_ADDR = 8'hA6;
  localparam logic [7:0] ENABLE_KEY_ADDR = 8'hAE;
  localparam logic [7:0] KEY_DISABLE_VALUE = 8'h55;
  localparam logic [7:0] RELOAD_RESET_VALUE = 8'h00;
  localparam int COUNT_WIDTH = 24;
  localparam logic [23:0] COUNT_RESET_VALUE = 24'h000000;
  localparam logic [23:0] COUNT_ALL_ONES = 24'hFFFFFF;
  localparam logic [15:0] COUNT_LOW_CLEAR = 16'h0000;
  localparam int BUS_CFG_WIDTH = 4;
  localparam int MCYCLE_CNT_WIDTH = 4;
  localparam logic [3:0] MCYCLE_DEFAULT_CLOCKS = 4'h4;
endpackage

/* machine_cycle_gen.sv */
// Machine cycle tick generator: one pulse at the end of each processor machine cycle.
`timescale 1ns/1ns
`default_nettype none
module machine_cycle_gen
  import watchdog_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic run_in,
  input wire logic [BUS_CFG_WIDTH-1:0] bus_cycle_config_in,
  input wire logic mem_transfer_in,
  input wire logic prefetch_branch_cache_stall_in,
  output logic tick_out
);
  logic [MCYCLE_CNT_WIDTH-1:0] phase_ff;
  logic [MCYCLE_CNT_WIDTH-1:0] nxt_phase;
  logic [MCYCLE_CNT_WIDTH-1:0] cycle_len;
  logic long_bus;
  logic at_end;
  logic nxt_tick;

  assign long_bus = mem_transfer_in && (bus_cycle_config_in > MCYCLE_DEFAULT_CLOCKS);
  assign cycle_len = long_bus ? bus_cycle_config_in : MCYCLE_DEFAULT_CLOCKS;
  assign at_end = (phase_ff >= cycle_len - 4'h1);
  // A stall holds the cycle open at its last clock, so the tick slips with it.
  assign nxt_tick = run_in && at_end && !prefetch_branch_cache_stall_in;
  assign nxt_phase = !run_in ? '0 : (nxt_tick ? '0 : (at_end ? phase_ff : phase_ff + 4'h1));

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      phase_ff <= '0;
      tick_out <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      tick_out <= nxt_tick;
    end
  end

  property p_min_spacing;
    @(posedge ref_clk_in) disable iff (srst_in)
      tick_out |=> !tick_out [*3];
  endproperty
  a_min_spacing: assert property (p_min_spacing) else $error("Machine cycle shorter than 4.");

  property p_stall_blocks;
    @(posedge ref_clk_in) disable iff (srst_in)
      prefetch_branch_cache_stall_in |=> !tick_out;
  endproperty
  a_stall_blocks: assert property (p_stall_blocks) else $error("Tick during a stall.");

  // Judged on the phase, so a transfer that ends mid-cycle does not trip it.
  property p_long_bus;
    @(posedge ref_clk_in) disable iff (srst_in)
      (run_in && mem_transfer_in && bus_cycle_config_in == 4'h6 && phase_ff < 4'h5)
        |=> !tick_out;
  endproperty
  a_long_bus: assert property (p_long_bus) else $error("Long bus cycle not stretched.");
endmodule
`default_nettype wire

/* watchdog_timer.sv */
// Watchdog timer: key and reload registers, 24-bit up-counter, reset request.
//
// What this block does
// - While enabled, counter overflow requests a system reset.
// - After any reset the watchdog stays disabled until firmware enables it.
// - No counting and no reset while idle or power-down.
// - Key 55h disables counting; any other key enables counting.
// - Every reset loads the key register with 55h.
// - Counter is 24 bits wide and cleared to 000000h by reset.
// - Enabled counter increments by one per machine cycle.
// - Overflow past all-ones issues reset and restores key to 55h.
// - Reload write loads upper byte and clears lower 16 bits.
// - Counting resumes upward from the reloaded value.
// - A machine cycle is 4 core clocks by default.
// - Longer memory bus cycles stretch machine cycles with transfers.
// - Prefetch or branch-cache stalls stretch the machine cycle.
// - Time-out is one source of the core and logic-module reset.
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer
  import watchdog_pkg::*;
#(
  parameter int BUS_CFG_W = BUS_CFG_WIDTH,
  // A narrower counter lets a bench reach overflow quickly; silicon keeps the default.
  parameter int CNT_W = COUNT_WIDTH
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic idle_mode_in,
  input wire logic power_down_mode_in,
  input wire logic [BUS_CFG_W-1:0] bus_cycle_config_in,
  input wire logic mem_transfer_in,
  input wire logic prefetch_branch_cache_stall_in,
  output logic wdt_reset_req_out,
  output logic enabled_out,
  output logic [CNT_W-1:0] count_out
);
  // The reload byte always fills the top eight bits; the rest is cleared.
  localparam int LOW_W = CNT_W - 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(COUNT_RESET_VALUE);
  localparam logic [CNT_W-1:0] CNT_ONES = CNT_W'(COUNT_ALL_ONES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [LOW_W-1:0] LOW_CLEAR = LOW_W'(COUNT_LOW_CLEAR);

  logic [7:0] key_ff;
  logic [7:0] nxt_key;
  logic [CNT_W-1:0] nxt_count;
  // Clocks since the last machine-cycle tick, saturating; only the checks read it.
  logic [MCYCLE_CNT_WIDTH-1:0] gap_ff;
  logic [MCYCLE_CNT_WIDTH-1:0] nxt_gap;
  logic gap_full;
  logic nxt_reset_req;
  logic active;
  logic enabled;
  logic counting;
  logic tick;
  logic key_wr;
  logic reload_wr;
  logic overflow;

  assign key_wr = sfr_wr_in && (sfr_addr_in == ENABLE_KEY_ADDR);
  assign reload_wr = sfr_wr_in && (sfr_addr_in == RELOAD_UPPER_BYTE_ADDR);
  assign active = !idle_mode_in && !power_down_mode_in;
  assign enabled = (key_ff != KEY_DISABLE_VALUE);
  assign counting = enabled && active && tick;
  // Overflow is the increment out of all-ones; a reload in the same cycle rescues it.
  assign overflow = counting && !reload_wr && (count_out == CNT_ONES);
  assign nxt_reset_req = overflow;
  // Overflow beats a simultaneous key write so the unit always ends disabled.
  assign nxt_key = overflow ? KEY_DISABLE_VALUE : (key_wr ? sfr_wdata_in : key_ff);
  assign nxt_count = reload_wr ? {sfr_wdata_in, LOW_CLEAR}
                   : (counting ? count_out + CNT_ONE : count_out);
  assign gap_full = (gap_ff == {MCYCLE_CNT_WIDTH{1'b1}});
  assign nxt_gap = tick ? '0 : (gap_full ? gap_ff : gap_ff + 4'h1);

  // The machine cycle generator runs only while the core is awake.
  machine_cycle_gen u_mcycle (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .run_in(active),
    .bus_cycle_config_in(bus_cycle_config_in[BUS_CFG_WIDTH-1:0]),
    .mem_transfer_in(mem_transfer_in),
    .prefetch_branch_cache_stall_in(prefetch_branch_cache_stall_in),
    .tick_out(tick)
  );

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      key_ff <= KEY_DISABLE_VALUE;
      count_out <= CNT_ZERO;
      wdt_reset_req_out <= 1'b0;
      enabled_out <= 1'b0;
    end else begin
      key_ff <= nxt_key;
      count_out <= nxt_count;
      wdt_reset_req_out <= nxt_reset_req;
      enabled_out <= (nxt_key != KEY_DISABLE_VALUE);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      gap_ff <= '0;
    end else begin
      gap_ff <= nxt_gap;
    end
  end

  property p_overflow_resets;
    @(posedge ref_clk_in) disable iff (srst_in)
      overflow |=> wdt_reset_req_out && count_out == CNT_ZERO;
  endproperty
  a_overflow_resets: assert property (p_overflow_resets) else $error("Overflow gave no reset.");

  property p_req_cause;
    @(posedge ref_clk_in) disable iff (srst_in)
      $rose(wdt_reset_req_out) |-> $past(enabled && active && tick);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("Reset request without cause.");

  property p_reset_state;
    @(posedge ref_clk_in)
      srst_in |=> key_ff == KEY_DISABLE_VALUE && count_out == CNT_ZERO && !enabled_out;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("Bad state after reset.");

  property p_sleep_quiet;
    @(posedge ref_clk_in) disable iff (srst_in)
      (!active && !reload_wr) |=> $stable(count_out) && !wdt_reset_req_out;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("Watchdog active in low power.");

  property p_disabled_holds;
    @(posedge ref_clk_in) disable iff (srst_in)
      (key_ff == KEY_DISABLE_VALUE && !reload_wr) |=> $stable(count_out);
  endproperty
  a_disabled_holds: assert property (p_disabled_holds) else $error("Counted while disabled.");

  property p_increment;
    @(posedge ref_clk_in) disable iff (srst_in)
      (counting && !reload_wr) |=> count_out == $past(count_out) + CNT_ONE;
  endproperty
  a_increment: assert property (p_increment) else $error("Count did not step by one.");

  property p_self_disable;
    @(posedge ref_clk_in) disable iff (srst_in)
      overflow |=> !enabled_out ##1 $stable(count_out) || $past(reload_wr);
  endproperty
  a_self_disable: assert property (p_self_disable) else $error("Key not restored on overflow.");

  property p_reload;
    @(posedge ref_clk_in) disable iff (srst_in)
      reload_wr |=> count_out == {$past(sfr_wdata_in), LOW_CLEAR};
  endproperty
  a_reload: assert property (p_reload) else $error("Reload value not loaded.");

  property p_pulse;
    @(posedge ref_clk_in) disable iff (srst_in)
      wdt_reset_req_out |=> !wdt_reset_req_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Reset request not a single pulse.");

  property p_key_enable;
    @(posedge ref_clk_in) disable iff (srst_in)
      (key_wr && sfr_wdata_in != KEY_DISABLE_VALUE && !overflow) |=> enabled_out;
  endproperty
  a_key_enable: assert property (p_key_enable) else $error("Key write did not enable.");

  property p_key_disable;
    @(posedge ref_clk_in) disable iff (srst_in)
      (key_wr && sfr_wdata_in == KEY_DISABLE_VALUE) |=> !enabled_out;
  endproperty
  a_key_disable: assert property (p_key_disable) else $error("Key write did not disable.");

  property p_no_req_disabled;
    @(posedge ref_clk_in) disable iff (srst_in)
      !enabled |=> !wdt_reset_req_out;
  endproperty
  a_no_req_disabled: assert property (p_no_req_disabled) else $error("Request while off.");

  property p_reload_rescues;
    @(posedge ref_clk_in) disable iff (srst_in)
      reload_wr |=> !wdt_reset_req_out;
  endproperty
  a_reload_rescues: assert property (p_reload_rescues) else $error("Reload did not rescue.");

  property p_hold_between;
    @(posedge ref_clk_in) disable iff (srst_in)
      (!counting && !reload_wr) |=> $stable(count_out);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("Count moved off a tick.");

  property p_req_zero_count;
    @(posedge ref_clk_in) disable iff (srst_in)
      wdt_reset_req_out |-> count_out == CNT_ZERO;
  endproperty
  a_req_zero_count: assert property (p_req_zero_count) else $error("Count not wrapped.");

  // Ticks closer than a default machine cycle would make the time-out too short.
  property p_tick_spacing;
    @(posedge ref_clk_in) disable iff (srst_in)
      tick |-> gap_ff >= MCYCLE_DEFAULT_CLOCKS - 4'h1;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("Machine cycle too short.");
endmodule
`default_nettype wire

/* sfr_core_model.sv */
// Processor core model that issues single-byte writes on the watchdog register path.
`timescale 1ns/1ns
`default_nettype none
module sfr_core_model (
  input wire logic ref_clk_in,
  input wire logic go_in,
  input wire logic [7:0] go_addr_in,
  input wire logic [7:0] go_data_in,
  output logic sfr_wr_out,
  output logic [7:0] sfr_addr_out,
  output logic [7:0] sfr_wdata_out
);
  initial begin
    sfr_wr_out = 1'b0;
    sfr_addr_out = 8'h00;
    sfr_wdata_out = 8'h00;
  end
  // Firmware reloads in time and picks a safe reload byte only as commanded.
  always @(posedge ref_clk_in) begin
    sfr_wr_out <= go_in;
    // An idle bus inverts address and data every clock, so the last byte and its inverse alternate.
    sfr_addr_out <= go_in ? go_addr_in : ~sfr_addr_out;
    sfr_wdata_out <= go_in ? go_data_in : ~sfr_wdata_out;
  end
endmodule
`default_nettype wire

/* watchdog_timer_tb.sv */
// Self-checking testbench for the watchdog timer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module watchdog_timer_tb;
  import watchdog_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst = 1'b1, idle = 1'b0, pdown = 1'b0, mem = 1'b0, stall = 1'b0, go = 1'b0;
  logic [3:0] bus_cfg = 4'h4;
  logic [7:0] go_addr = 8'h00, go_data = 8'h00, wr_addr, wr_data;
  logic wr, req, en;
  logic [15:0] cnt, c0;
  int fails = 0, n_compared = 0, k;
  sfr_core_model core (.ref_clk_in(ref_clk_in), .go_in(go), .go_addr_in(go_addr),
    .go_data_in(go_data), .sfr_wr_out(wr), .sfr_addr_out(wr_addr), .sfr_wdata_out(wr_data));
  // The request feeds back into the system reset, as the outside reset logic does.
  // A 16-bit counter keeps the overflow run short; the reload byte still lands on top.
  watchdog_timer #(.CNT_W(16)) uut (.ref_clk_in(ref_clk_in), .srst_in(rst | req), .sfr_wr_in(wr),
    .sfr_addr_in(wr_addr), .sfr_wdata_in(wr_data), .idle_mode_in(idle),
    .power_down_mode_in(pdown), .bus_cycle_config_in(bus_cfg), .mem_transfer_in(mem),
    .prefetch_branch_cache_stall_in(stall), .wdt_reset_req_out(req), .enabled_out(en),
    .count_out(cnt));
  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  task automatic results();
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    go <= 1'b1;
    go_addr <= a;
    go_data <= d;
    @(posedge ref_clk_in);
    go <= 1'b0;
    tick(1);
  endtask
  task automatic sync_change();
    c0 = cnt;
    for (k = 0; k < 40 && cnt === c0; k++) tick(1);
    if (cnt === c0) begin
      fails++;
      results();
    end
    c0 = cnt;
  endtask
  // Checks one machine cycle of n clocks: count holds, then steps by one.
  task automatic period(input int n);
    sync_change();
    tick(n - 1);
    `CHK("count hold", c0, cnt)
    tick(1);
    `CHK("count step", c0 + 16'h0001, cnt)
  endtask
  task automatic frozen(input string nm);
    tick(2);
    c0 = cnt;
    tick(12);
    `CHK(nm, c0, cnt)
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst <= 1'b0;
    tick(1);
    `CHK("enabled", 1'b0, en)
    `CHK("count", COUNT_RESET_VALUE[15:0], cnt)
    write(RELOAD_UPPER_BYTE_ADDR, 8'h04);
    `CHK("reload", {8'h04, COUNT_LOW_CLEAR[7:0]}, cnt)
    write(8'h10, 8'hAA);
    tick(12);
    `CHK("disabled count", {8'h04, COUNT_LOW_CLEAR[7:0]}, cnt)
    `CHK("unmapped", 1'b0, en)
    write(ENABLE_KEY_ADDR, 8'hAA);
    `CHK("enabled", 1'b1, en)
    period(4);
    `CHK("upper byte", 8'h04, cnt[15:8])
    @(posedge ref_clk_in);
    mem <= 1'b1;
    bus_cfg <= 4'h6;
    period(6);
    @(posedge ref_clk_in);
    mem <= 1'b0;
    sync_change();
    @(posedge ref_clk_in);
    stall <= 1'b1;
    tick(12);
    `CHK("stall", c0, cnt)
    @(posedge ref_clk_in);
    stall <= 1'b0;
    period(4);
    @(posedge ref_clk_in);
    idle <= 1'b1;
    frozen("idle");
    @(posedge ref_clk_in);
    idle <= 1'b0;
    pdown <= 1'b1;
    frozen("power down");
    @(posedge ref_clk_in);
    pdown <= 1'b0;
    write(ENABLE_KEY_ADDR, KEY_DISABLE_VALUE);
    `CHK("key off", 1'b0, en)
    write(RELOAD_UPPER_BYTE_ADDR, 8'hFF);
    write(ENABLE_KEY_ADDR, 8'h3C);
    // From FF00h the bench counter needs 256 machine cycles; the bound leaves margin.
    for (k = 0; k < 2000 && req !== 1'b1; k++) begin
      c0 = cnt;
      tick(1);
    end
    `CHK("request", 1'b1, req)
    `CHK("last count", COUNT_ALL_ONES[15:0], c0)
    `CHK("wrapped", COUNT_RESET_VALUE[15:0], cnt)
    `CHK("self off", 1'b0, en)
    tick(1);
    `CHK("pulse", 1'b0, req)
    `CHK("after reset", 1'b0, en)
    results();
  end
endmodule
`default_nettype wire
